// >>> hdl/sleep_ctl_pkg.sv
// shared constants and types for the mute/idle/sleep controller
package sleep_ctl_pkg;
  // clock period of clk_sys in ns (200 MHz)
  localparam int unsigned CLK_PERIOD_NS = 5;
  // base timeout tick period in ns, scaled by the units selector
  localparam int unsigned BASE_TICK_NS  = 1_000_000;
  // widths of the configuration fields
  localparam int unsigned TOUT_W        = 4;   // mute / idle / init count
  localparam int unsigned UNITS_W       = 2;   // timeout-units selector
  localparam int unsigned MSG_CNT_W     = 6;   // messages before self mute
  localparam int unsigned HOLD_W        = 4;   // max hold-off field
  localparam int unsigned SLEEP_W       = 4;   // sleep timeout field
  localparam int unsigned TMR_W         = 6;   // common timer count width
  // unit-tick prescale masks per units selector (x1, x4, x16, x64)
  localparam logic [5:0] UNIT_MASK0     = 6'h00;
  localparam logic [5:0] UNIT_MASK1     = 6'h03;
  localparam logic [5:0] UNIT_MASK2     = 6'h0f;
  localparam logic [5:0] UNIT_MASK3     = 6'h3f;
  // active-window multipliers for the sleep encouragement modes
  localparam logic [2:0] TOT_LAPS       = 3'h2;
  localparam logic [2:0] INIT_LAPS      = 3'h6;
  localparam logic [2:0] IDLE_LAPS      = 3'h2;
  // hold-off counts in base ticks, units selector fixed at x1
  localparam logic [1:0] HOLD_UNITS     = 2'h0;
  // power / link states
  typedef enum logic [2:0]
  {
    ST_SLEEP,
    ST_BOOT,
    ST_TX,
    ST_LISTEN,
    ST_MUTED,
    ST_READY
  } pstate_t;
endpackage

// >>> hdl/pin_edge_sync.sv
// two-flop synchroniser with rising-edge pulse for a pin input
module pin_edge_sync
(
  input  wire logic clk_sys,   // system clock
  input  wire logic rst_b,     // async reset, active low
  input  wire logic ce,        // clock enable
  input  wire logic pin,       // raw pin level
  output logic      level,     // synchronised level
  output logic      rise       // one-cycle rising-edge pulse
);
  logic meta_q;   // first stage, read only by sync_q
  logic sync_q;   // second stage
  logic prev_q;   // delayed copy for the edge detect

  // synchroniser chain and edge history
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else if (ce)
    begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end

  assign level = sync_q;
  // edge only from settled samples
  assign rise  = sync_q & ~prev_q;
endmodule

// >>> hdl/unit_timer.sv
// timeout counter: count of unit ticks, unit set by a 2-bit selector
module unit_timer
  import sleep_ctl_pkg::*;
#(
  parameter int unsigned W = TMR_W   // count width
)
(
  input  wire logic         clk_sys,  // system clock
  input  wire logic         rst_b,    // async reset, active low
  input  wire logic         ce,       // clock enable
  input  wire logic         tick,     // base tick pulse
  input  wire logic         restart,  // clear and start over
  input  wire logic         run,      // count while high
  input  wire logic [1:0]   units,    // timeout-units selector
  input  wire logic [W-1:0] count,    // timeout in units, zero never ends
  output logic              expired   // one-cycle pulse, then rearms
);
  logic [5:0]   sub_q;     // base ticks within one unit
  logic [W-1:0] cnt_q;     // elapsed units
  logic [5:0]   mask;      // prescale terminal value
  logic         unit_tick; // one unit elapsed

  // units selector to prescale mask
  always_comb
    case (units)
      2'h0:    mask = UNIT_MASK0;
      2'h1:    mask = UNIT_MASK1;
      2'h2:    mask = UNIT_MASK2;
      default: mask = UNIT_MASK3;
    endcase

  assign unit_tick = run & tick & (sub_q == mask);
  // a zero count never fires
  assign expired   = unit_tick & (count != '0) & (cnt_q == count - W'(1));

  // prescaler within a unit
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      sub_q <= 6'h00;
    else if (ce)
    begin
      if (restart)
        sub_q <= 6'h00;
      else if (run && tick)
        sub_q <= (sub_q == mask) ? 6'h00 : sub_q + 6'h01;
    end

  // unit counter, wraps on expiry so laps can be counted
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      cnt_q <= '0;
    else if (ce)
    begin
      if (restart || expired)
        cnt_q <= '0;
      else if (unit_tick)
        cnt_q <= cnt_q + W'(1);
    end
endmodule

// >>> hdl/sleep_ctl.sv
// active/sleep, mute and idle timeout controller of the tag
module sleep_ctl
  import sleep_ctl_pkg::*;
#(
  // base tick length in clk_sys cycles
  parameter int unsigned TICK_CYC = BASE_TICK_NS / CLK_PERIOD_NS
)
(
  input  wire logic                 clk_sys,            // system clock
  input  wire logic                 rst_b,              // async reset, active low
  input  wire logic                 ce,                 // clock enable
  input  wire logic                 rf_field_present,   // field above threshold
  input  wire logic                 boot_done,          // boot sequence complete
  input  wire logic                 total_mode,         // tag talks first
  input  wire logic                 battery_assisted_operation, // battery mode
  input  wire logic                 serial_param_setting_command, // sens. set
  input  wire logic                 spi_mode,           // port as serial bus
  input  wire logic                 p3_wake_enable,     // pin3 edge ends mute, not in spi mode
  input  wire logic                 mute_timeout_enable,// mute timeout on
  input  wire logic                 idle_timeout_enable,// idle timeout on
  input  wire logic [MSG_CNT_W-1:0] self_mute_msgs,     // msgs before mute
  input  wire logic [TOUT_W-1:0]    mute_timeout,       // mute timeout count
  input  wire logic [UNITS_W-1:0]   mute_units,         // mute timeout units
  input  wire logic [TOUT_W-1:0]    idle_timeout,       // idle timeout count
  input  wire logic [UNITS_W-1:0]   idle_units,         // idle timeout units
  input  wire logic [TOUT_W-1:0]    init_cmd_timeout,   // first-command limit
  input  wire logic [SLEEP_W-1:0]   sleep_timeout,      // forced sleep count
  input  wire logic [HOLD_W-1:0]    max_holdoff,        // message spacing
  input  wire logic                 msg_done,           // message sent, pulse
  input  wire logic                 mute_cmd,           // mute condition, pulse
  input  wire logic                 rtf_cmd_valid,      // reader command, pulse
  input  wire logic                 port_bit3_or_chip_select, // pin3 level
  input  wire logic                 port_bit2_or_serial_clock, // pin2 level
  output logic                      active,             // active mode
  output logic                      muted,              // tag muted
  output logic                      tx_start,           // send message, pulse
  output logic                      cmd_accept,         // commands taken
  output logic                      forced_sleep,       // duty-cycled off
  output logic                      chip_select,        // spi select, high
  output logic                      serial_clock        // spi clock
);
  localparam int unsigned PRE_W = $clog2(TICK_CYC + 1);

  pstate_t           state_q;    // current state
  pstate_t           state_d;    // next state
  logic [PRE_W-1:0]  pre_q;      // base tick prescaler
  logic              tick;       // base tick pulse
  logic [MSG_CNT_W-1:0] msg_q;   // messages since unmute
  logic [2:0]        laps_q;     // window or mute laps elapsed
  logic              forced_q;   // sleep entered by a timeout
  logic              seen_cmd_q; // first command seen since boot
  logic              tx_q;       // start pulse register
  logic              cs_q;       // chip select register
  logic              sclk_q;     // serial clock register
  logic              p3_level;   // synchronised pin3
  logic              p3_rise;    // pin3 rising edge
  logic              st_restart; // restart of state timer
  logic              st_run;     // state timer runs
  logic [1:0]        st_units;   // state timer units
  logic [TMR_W-1:0]  st_count;   // state timer count
  logic              st_exp;     // state timer expiry
  logic              win_restart;// restart of window timer
  logic              win_run;    // window timer runs
  logic [TMR_W-1:0]  win_count;  // window lap length
  logic              win_exp;    // window lap expiry
  logic              mute_tmo_on;// mute timeout usable
  logic              idle_tmo_on;// idle timeout usable
  logic              tot_enc;    // total sleep encouragement
  logic              rtf_enc;    // reader-first sleep encouragement
  logic              msg_limit;  // self-mute count reached
  logic              win_over;   // encouraged window used up
  logic              go_sleep;   // forced sleep request this cycle

  pin_edge_sync u_p3
  (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .ce      (ce),
    .pin     (port_bit3_or_chip_select),
    .level   (p3_level),
    .rise    (p3_rise)
  );

  // base tick prescaler; long, so shortened by TICK_CYC in simulation
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      pre_q <= '0;
    else if (ce)
      pre_q <= tick ? '0 : pre_q + PRE_W'(1);

  assign tick = (pre_q == PRE_W'(TICK_CYC - 1));

  // mute timeout needs its enable and a nonzero count
  assign mute_tmo_on = mute_timeout_enable & (mute_timeout != '0);
  // idle timeout needs its enable and a nonzero count
  assign idle_tmo_on = idle_timeout_enable & (idle_timeout != '0);

  // all six conditions for total encouragement
  assign tot_enc = battery_assisted_operation & idle_timeout_enable
                 & (sleep_timeout != '0) & (self_mute_msgs != '0)
                 & (mute_timeout != '0) & ~serial_param_setting_command;

  // all four conditions for reader-first encouragement
  assign rtf_enc = battery_assisted_operation & (sleep_timeout != '0)
                 & (idle_timeout != '0) & ~serial_param_setting_command;

  assign msg_limit = (self_mute_msgs != '0)
                   & (msg_q == self_mute_msgs - MSG_CNT_W'(1));

  // state timer selection per state
  always_comb
  begin
    st_run   = 1'b0;
    st_units = HOLD_UNITS;
    st_count = '0;
    case (state_q)
      ST_LISTEN:
      begin
        st_run   = 1'b1;
        st_count = TMR_W'(max_holdoff);
      end
      ST_MUTED:
      begin
        st_run   = mute_tmo_on;
        st_units = mute_units;
        st_count = TMR_W'(mute_timeout);
      end
      ST_READY:
      begin
        st_run   = idle_tmo_on;
        st_units = idle_units;
        st_count = TMR_W'(idle_timeout);
      end
      ST_SLEEP:
      begin
        // off time only after a forced sleep
        st_run   = forced_q;
        st_units = idle_units;
        st_count = TMR_W'(sleep_timeout);
      end
      default:
      begin
        st_run   = 1'b0;
      end
    endcase
  end

  // each new state, mute included, restarts the timer
  assign st_restart = (state_d != state_q)
                    | ((state_q == ST_READY) & rtf_cmd_valid);

  unit_timer #(.W(TMR_W)) u_state_tmr
  (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .ce      (ce),
    .tick    (tick),
    .restart (st_restart),
    .run     (st_run),
    .units   (st_units),
    .count   (st_count),
    .expired (st_exp)
  );

  // window lap length: init timeout, else idle timeout
  always_comb
  begin
    win_count = TMR_W'(idle_timeout);
    if (init_cmd_timeout != '0)
      win_count = TMR_W'(init_cmd_timeout);
  end

  // window counts only in reader-first active time
  assign win_run     = (state_q == ST_READY);
  assign win_restart = (state_q == ST_BOOT);

  unit_timer #(.W(TMR_W)) u_window_tmr
  (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .ce      (ce),
    .tick    (tick),
    .restart (win_restart),
    .run     (win_run),
    .units   (idle_units),
    .count   (win_count),
    .expired (win_exp)
  );

  // encouraged active window used up
  always_comb
  begin
    win_over = 1'b0;
    if (state_q == ST_READY && rtf_enc && win_exp)
    begin
      // six laps of the init timeout
      if (init_cmd_timeout != '0)
        win_over = (laps_q == INIT_LAPS - 3'h1);
      // two laps of the idle timeout
      else
        win_over = (laps_q == IDLE_LAPS - 3'h1);
    end
  end

  // forced sleep causes of this cycle
  always_comb
  begin
    go_sleep = 1'b0;
    case (state_q)
      ST_READY:
      begin
        if (st_exp)
          go_sleep = 1'b1;
        // no first command within the init timeout
        if (win_exp && !seen_cmd_q && init_cmd_timeout != '0)
          go_sleep = 1'b1;
        if (win_over)
          go_sleep = 1'b1;
      end
      ST_MUTED:
      begin
        if (tot_enc && st_exp && laps_q == TOT_LAPS - 3'h1)
          go_sleep = 1'b1;
      end
      default:
      begin
        go_sleep = 1'b0;
      end
    endcase
  end

  // next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_SLEEP:
      begin
        // forced off time holds off the wake
        if (rf_field_present && (!forced_q || st_exp || sleep_timeout == '0))
          state_d = ST_BOOT;
      end
      ST_BOOT:
      begin
        if (boot_done)
          state_d = total_mode ? ST_TX : ST_READY;
      end
      ST_TX:
      begin
        if (msg_done)
          state_d = msg_limit ? ST_MUTED : ST_LISTEN;
      end
      ST_LISTEN:
      begin
        if (mute_cmd)
          state_d = ST_MUTED;
        else if (st_exp)
          state_d = ST_TX;
      end
      ST_MUTED:
      begin
        // encouraged total tag goes to sleep
        if (go_sleep)
          state_d = ST_SLEEP;
        else if (p3_wake_enable && !spi_mode && p3_rise)
          state_d = ST_TX;
        else if (st_exp)
          state_d = ST_TX;
      end
      ST_READY:
      begin
        // stay ready unless a timeout fires
        if (go_sleep)
          state_d = ST_SLEEP;
      end
      default:
      begin
        state_d = ST_SLEEP;
      end
    endcase
    // field loss ends everything, mute included
    if (!rf_field_present && state_q != ST_SLEEP)
      state_d = ST_SLEEP;
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      state_q <= ST_SLEEP;
    else if (ce)
      state_q <= state_d;

  // forced-sleep flag; plain field loss never forces an off time
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      forced_q <= 1'b0;
    else if (ce)
    begin
      if (state_d == ST_SLEEP && state_q != ST_SLEEP)
        forced_q <= go_sleep & rf_field_present;
      else if (state_d != ST_SLEEP)
        forced_q <= 1'b0;
    end

  // message count since the last unmute
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      msg_q <= '0;
    else if (ce)
    begin
      if (state_q == ST_MUTED || state_q == ST_SLEEP)
        msg_q <= '0;
      else if (state_q == ST_TX && msg_done)
        msg_q <= msg_q + MSG_CNT_W'(1);
    end

  // lap counter for the repeating cycles
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      laps_q <= 3'h0;
    else if (ce)
    begin
      if (state_q == ST_BOOT || state_q == ST_SLEEP)
        laps_q <= 3'h0;
      else if (state_q == ST_MUTED && st_exp && tot_enc)
        laps_q <= laps_q + 3'h1;
      else if (state_q == ST_READY && win_exp)
        laps_q <= laps_q + 3'h1;
    end

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      seen_cmd_q <= 1'b0;
    else if (ce)
    begin
      if (state_q == ST_BOOT)
        seen_cmd_q <= 1'b0;
      else if (cmd_accept && rtf_cmd_valid)
        seen_cmd_q <= 1'b1;
    end

  // message start pulse on entry to transmit
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      tx_q <= 1'b0;
    else if (ce)
      tx_q <= (state_d == ST_TX) & (state_q != ST_TX);

  // pin3 as active-low select, pin2 as clock in spi mode
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      cs_q   <= 1'b0;
      sclk_q <= 1'b0;
    end
    else if (ce)
    begin
      cs_q   <= spi_mode & ~p3_level;
      sclk_q <= spi_mode & port_bit2_or_serial_clock;
    end

  // outputs
  assign active       = (state_q != ST_SLEEP);
  assign muted        = (state_q == ST_MUTED);
  assign tx_start     = tx_q;
  assign forced_sleep = (state_q == ST_SLEEP) & forced_q;
  assign chip_select  = cs_q;
  assign serial_clock = sclk_q;
  // commands taken except while booting or sending; none while asleep
  assign cmd_accept   = (state_q != ST_SLEEP) & (state_q != ST_TX)
                      & (state_q != ST_BOOT);
endmodule

// >>> sim/sleep_ctl_sva.sv
// checker for the mute/idle/sleep controller ports
module sleep_ctl_sva
  import sleep_ctl_pkg::*;
#(
  parameter int unsigned TICK_CYC = 4  // base tick length in cycles
)
(
  input wire logic                                 clk_sys,          // clock
  input wire logic                                 rst_b,            // reset, low
  input wire logic                                 ce,               // clock enable
  input wire logic                                 rf_field_present, // field
  input wire logic                                 spi_mode,         // serial bus
  input wire logic                                 p3_wake_enable,   // pin wake
  input wire logic                                 mute_timeout_enable, // on
  input wire logic [sleep_ctl_pkg::TOUT_W-1:0]     mute_timeout,     // count
  input wire logic [sleep_ctl_pkg::UNITS_W-1:0]    mute_units,       // units
  input wire logic                                 port_bit3_or_chip_select, // pin
  input wire logic                                 active,           // active
  input wire logic                                 muted,            // muted
  input wire logic                                 tx_start,         // send
  input wire logic                                 cmd_accept,       // commands
  input wire logic                                 forced_sleep,     // off time
  input wire logic                                 chip_select       // select
);
  // one unit is a tick; allow phase of the free prescaler plus sync
  localparam int MT_HI = 2 * TICK_CYC + 4;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_field_loss;
    ce && !rf_field_present |=> !active && !muted;
  endproperty
  a_field_loss: assert property (p_field_loss)
    else $error("still active after field loss");
  property p_mute_hold;
    ce && muted && rf_field_present && !p3_wake_enable && !mute_timeout_enable |=> muted;
  endproperty
  a_mute_hold: assert property (p_mute_hold)
    else $error("mute ended without cause");
  property p_wake;
    ce && muted && p3_wake_enable && !spi_mode && $rose(port_bit3_or_chip_select)
      |-> ##[1:5] !muted;
  endproperty
  a_wake: assert property (p_wake)
    else $error("pin rise did not end mute");
  property p_resume;
    $fell(muted) && active |-> ##[0:1] tx_start;
  endproperty
  a_resume: assert property (p_resume)
    else $error("no message after mute end");
  property p_mute_tout;
    $rose(muted) && mute_timeout_enable && mute_timeout == 4'h1 && mute_units == 2'h0
      |-> ##[1:MT_HI] !muted;
  endproperty
  a_mute_tout: assert property (p_mute_tout)
    else $error("mute timeout late");
  property p_tx_deaf;
    tx_start |-> !cmd_accept && !muted;
  endproperty
  a_tx_deaf: assert property (p_tx_deaf)
    else $error("command taken during send");
  property p_mute_listen;
    muted |-> cmd_accept && active;
  endproperty
  a_mute_listen: assert property (p_mute_listen)
    else $error("muted tag not listening");
  property p_off_deaf;
    !active || forced_sleep |-> !cmd_accept;
  endproperty
  a_off_deaf: assert property (p_off_deaf)
    else $error("command taken while off");
  // low pin selects in serial mode
  property p_cs_on;
    (spi_mode && !port_bit3_or_chip_select) [*4] |-> chip_select;
  endproperty
  a_cs_on: assert property (p_cs_on)
    else $error("select missing");
  property p_cs_off;
    !spi_mode [*2] |-> !chip_select;
  endproperty
  a_cs_off: assert property (p_cs_off)
    else $error("select outside serial mode");
endmodule
bind sleep_ctl sleep_ctl_sva #(.TICK_CYC(TICK_CYC)) sleep_ctl_sva_i (.*);

// >>> sim/reader_model.sv
// reader side: ends messages and mutes the tag on request
module reader_model
(
  input  wire logic       clk_sys,  // system clock
  input  wire logic       tx_start, // tag starts a message
  input  wire logic       mute_en,  // mute after each message
  input  wire logic [3:0] lat,      // message length, 0 is prompt
  output logic            msg_done, // message finished, pulse
  output logic            mute_cmd  // mute order, pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;  // cycles left in message
  initial
  begin
    msg_done = 1'b0;
    mute_cmd = 1'b0;
    cnt_q    = 4'h0;
  end
  // driven off the sampling edge; mute follows end of message
  always @(negedge clk_sys)
  begin
    msg_done <= 1'b0;
    mute_cmd <= msg_done & mute_en;
    if (tx_start && lat == 4'h0)
      msg_done <= 1'b1;
    else if (tx_start)
      cnt_q <= lat;
    else if (cnt_q != 4'h0)
    begin
      cnt_q    <= cnt_q - 4'h1;
      msg_done <= (cnt_q == 4'h1);
    end
  end
endmodule

// >>> sim/sleep_ctl_tb.sv
// self-checking bench for the mute/idle/sleep controller
module sleep_ctl_tb;
  import sleep_ctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TICK = 4;  // short base tick keeps run brief
  logic clk_sys, rst_b, ce, rf_field_present, boot_done, total_mode, spi_mode;
  logic battery_assisted_operation, serial_param_setting_command, p3_wake_enable;
  logic mute_timeout_enable, idle_timeout_enable, msg_done, mute_cmd, rtf_cmd_valid;
  logic port_bit3_or_chip_select, port_bit2_or_serial_clock, mute_en;
  logic [MSG_CNT_W-1:0] self_mute_msgs;
  logic [TOUT_W-1:0]    mute_timeout, idle_timeout, init_cmd_timeout;
  logic [UNITS_W-1:0]   mute_units, idle_units;
  logic [SLEEP_W-1:0]   sleep_timeout;
  logic [HOLD_W-1:0]    max_holdoff;
  logic [3:0]           lat;
  logic active, muted, tx_start, cmd_accept, forced_sleep, chip_select, serial_clock;
  int                   mismatches, cmp_count, cyc, n, gap;
  // rows: serial mode, pin3, pin2, expected select
  logic [3:0]           rows [4] = '{4'hb, 4'hc, 4'h9, 4'h2};
  sleep_ctl #(.TICK_CYC(TICK)) sleep_ctl_i (.*);
  reader_model reader_model_i (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_on(input bit sel, input logic lvl);
    int k;
    k = 0;
    while (((sel ? active : muted) !== lvl) && k < 400)
    begin
      @(negedge clk_sys);
      k++;
    end
  endtask
  task automatic end_of_test;
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, well above the expected length
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      end_of_test();
    end
  end
  initial
  begin
    {rst_b, rf_field_present, boot_done, total_mode, spi_mode, p3_wake_enable} = '0;
    {battery_assisted_operation, serial_param_setting_command, rtf_cmd_valid} = '0;
    {mute_timeout_enable, idle_timeout_enable, mute_en, port_bit2_or_serial_clock} = '0;
    {self_mute_msgs, mute_timeout, idle_timeout, init_cmd_timeout, sleep_timeout} = '0;
    {mute_units, idle_units, port_bit3_or_chip_select} = '0;
    ce = 1'b1;
    max_holdoff = 4'h2;
    lat = 4'h3;
    repeat (2) @(negedge clk_sys);
    chk({active, muted, tx_start, cmd_accept, forced_sleep, chip_select}, 8'h00);
    rst_b = 1'b1;
    // pin rows in serial and plain mode
    foreach (rows[i])
    begin
      {spi_mode, port_bit3_or_chip_select, port_bit2_or_serial_clock} = rows[i][3:1];
      repeat (4) @(negedge clk_sys);
      chk(chip_select, rows[i][0]);
      if (spi_mode)
        chk(serial_clock, rows[i][1]);
    end
    {spi_mode, port_bit3_or_chip_select} = 2'h0;
    // two messages, then self mute
    total_mode = 1'b1;
    self_mute_msgs = 6'h02;
    rf_field_present = 1'b1;
    repeat (3) @(negedge clk_sys);
    boot_done = 1'b1;
    n = 0;
    gap = 0;
    for (int c = 0; c < 300 && muted !== 1'b1; c++)
    begin
      @(negedge clk_sys);
      n += tx_start;
      gap += (n == 1);
    end
    chk(n, 2);
    chk(gap >= 2 * TICK - 1, 1'b1);
    // pin pulse without wake enabled does not end mute
    repeat (10) @(negedge clk_sys);
    port_bit3_or_chip_select = 1'b1;
    repeat (20) @(negedge clk_sys);
    port_bit3_or_chip_select = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk(muted, 1'b1);
    p3_wake_enable = 1'b1;
    spi_mode = 1'b1;
    port_bit3_or_chip_select = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk(muted, 1'b1);
    spi_mode = 1'b0;
    port_bit3_or_chip_select = 1'b0;
    repeat (4) @(negedge clk_sys);
    port_bit3_or_chip_select = 1'b1;
    wait_on(0, 1'b0);
    chk(muted, 1'b0);
    // reader mutes, timeout ends it, prompt partner
    lat = 4'h0;
    self_mute_msgs = 6'h00;
    mute_en = 1'b1;
    mute_timeout_enable = 1'b1;
    mute_timeout = 4'h1;
    wait_on(0, 1'b1);
    chk(muted, 1'b1);
    wait_on(0, 1'b0);
    chk(muted, 1'b0);
    rf_field_present = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(active, 1'b0);
    // reader first: commands hold off idle timeout
    {total_mode, mute_en} = 2'h0;
    idle_timeout_enable = 1'b1;
    idle_timeout = 4'h3;
    rf_field_present = 1'b1;
    wait_on(1, 1'b1);
    repeat (10)
    begin
      repeat (5) @(negedge clk_sys);
      rtf_cmd_valid = 1'b1;
      @(negedge clk_sys);
      rtf_cmd_valid = 1'b0;
    end
    chk({active, cmd_accept}, 8'h03);
    wait_on(1, 1'b0);
    chk(forced_sleep, 1'b1);
    idle_timeout_enable = 1'b0;
    wait_on(1, 1'b1);
    repeat (100) @(negedge clk_sys);
    chk(active, 1'b1);
    // no first command: back to sleep, then sleep timer
    battery_assisted_operation = 1'b1;
    idle_timeout_enable = 1'b1;
    {idle_timeout, init_cmd_timeout, sleep_timeout} = {4'hf, 4'h1, 4'h2};
    rf_field_present = 1'b0;
    repeat (2) @(negedge clk_sys);
    rf_field_present = 1'b1;
    wait_on(1, 1'b1);
    wait_on(1, 1'b0);
    chk(forced_sleep, 1'b1);
    n = 0;
    while (active !== 1'b1 && n < 400)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk(n >= TICK && active === 1'b1, 1'b1);
    // encouraged total tag: two mute cycles, then forced sleep
    {total_mode, self_mute_msgs} = {1'b1, 6'h01};
    n = 0;
    for (int c = 0; c < 400 && active === 1'b1; c++)
    begin
      @(negedge clk_sys);
      n += tx_start;
    end
    chk(n, 2);
    chk(forced_sleep, 1'b1);
    // encouraged reader-first tag: two idle laps despite commands
    {total_mode, init_cmd_timeout, idle_timeout} = {1'b0, 4'h0, 4'h3};
    wait_on(1, 1'b1);
    n = 0;
    while (active === 1'b1 && n < 400)
    begin
      // commands keep the idle timer from ever expiring
      rtf_cmd_valid = (n % 3 == 0);
      @(negedge clk_sys);
      n++;
    end
    rtf_cmd_valid = 1'b0;
    chk(n >= 6 * TICK - 4 && n <= 6 * TICK + 4, 1'b1);
    chk(forced_sleep, 1'b1);
    rst_b = 1'b0;
    @(negedge clk_sys);
    chk({active, muted, cmd_accept, forced_sleep}, 8'h00);
    // release with the enable low: nothing may move
    ce = 1'b0;
    rst_b = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(active, 1'b0);
    // reset cleared the forced off time, so wake at once
    ce = 1'b1;
    @(negedge clk_sys);
    chk({active, cmd_accept}, 8'h02);
    @(negedge clk_sys);
    chk({active, cmd_accept}, 8'h03);
    end_of_test();
  end
endmodule
